// file: cmcf_pkg.sv
// constants for the message center filter block
package cmcf_pkg;
  // ---------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------
  localparam int NC = 15;
  localparam int MW = 64;
  localparam int PW = 6;
  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] A_GCTRL = 8'h00;
  localparam logic [7:0] A_BTIME = 8'h01;
  localparam logic [7:0] A_IDMSK = 8'h02;
  localparam logic [7:0] A_MALO = 8'h03;
  localparam logic [7:0] A_MAHI = 8'h04;
  localparam logic [7:0] A_MAMSK = 8'h05;
  localparam logic [7:0] A_ISTAT = 8'h06;
  localparam logic [7:0] A_IMASK = 8'h07;
  localparam logic [7:0] A_SRC = 8'h08;
  localparam logic [7:0] A_PTR = 8'h09;
  localparam logic [7:0] A_BUF = 8'h0A;
  localparam logic [7:0] A_CTL = 8'h10;
  // ---------------------------------------------------------------
  // center control fields
  // ---------------------------------------------------------------
  localparam int C_DIR = 0;
  localparam int C_IEN = 1;
  localparam int C_EXT = 2;
  localparam int C_DATA_UPDATED = 3;
  localparam int C_RDY = 4;
  localparam int C_TRQ = 5;
  localparam int C_TIH = 6;
  localparam int C_MSK = 7;
  localparam int C_DLC = 12;
  localparam int S_OVR = 15;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] CTL_RST = 16'h0000;
  localparam logic [28:0] IDMSK_RST = 29'h1FFF_FFFF;
  localparam logic [15:0] MAMSK_RST = 16'h0000;
  localparam logic [15:0] BTIME_RST = 16'h0000;
endpackage

// file: cmcf_top.sv
// message centers, acceptance filter and shared message memory
// Notes on behaviour
// - standard and extended frames are both filtered and answered.
// - fifteen centers each hold an identifier and eight data bytes.
// - centers one to fourteen select an 11-bit or a 29-bit identifier mode; fifteen takes both.
// - centers one to fourteen are set to transmit or receive.
// - center fifteen only receives and takes data frames nobody else took.
// - centers one to fourteen accept only when the masked identifier matches.
// - for centers one to fourteen the first two data bytes must match the media arbitration bytes.
// - global mask bits remove positions from the comparison.
// - transmit-ready means dir 1, inhibit 0, updated, ready, request.
// - a remote frame with a ready center's identifier triggers it.
// - identifiers and data live in one memory shared by both sides.
// - the protocol engine reads the memory directly; its received frames are written in by the filter.
// - software reaches the memory only through pointer and buffer.
// - global registers give errors, new data, timing, mask, source.
// - each center has direction, irq, mode, length, status controls.
//
// Local design decisions: the placing of the registers and the strobed register port.
module cmcf_top
  import cmcf_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic rx_valid,
  input wire logic rx_ide,
  input wire logic rx_rtr,
  input wire logic [28:0] rx_id,
  input wire logic [3:0] rx_dlc,
  input wire logic [63:0] rx_data,
  input wire logic eng_rd,
  input wire logic [5:0] eng_addr,
  output logic [31:0] eng_rdata,
  output logic tx_go,
  output logic [3:0] tx_center,
  output logic rx_stored,
  output logic can_enable,
  output logic [15:0] bit_timing,
  output logic irq
);
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic id_ok(input logic [28:0] sid,
    input logic [28:0] rid, input logic ext, input logic [28:0] msk);
    logic [28:0] d;
    d = (sid ^ rid) & msk;
    if (!ext)
      d[28:11] = 18'h0_0000;
    return d == 29'h0000_0000;
  endfunction

  function automatic logic [3:0] low_idx(input logic [NC-1:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = NC - 1; i >= 0; i--)
      if (v[i])
        r = 4'(i + 1);
    return r;
  endfunction

  function automatic logic [PW-1:0] mbase(input logic [3:0] c);
    return {c - 4'h1, 2'b00};
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [31:0] mem [0:MW-1];
  logic [15:0] cctl [1:NC];
  logic [28:0] id_mask;
  logic [7:0] media_arb_byte_lo;
  logic [7:0] media_arb_byte_hi;
  logic [15:0] media_mask;
  logic [15:0] int_status;
  logic [15:0] int_mask;
  logic [3:0] last_src;
  logic [PW-1:0] can_mem_pointer;
  logic [NC-1:0] hit;
  logic [NC-1:0] ans;
  logic [3:0] rx_win;
  logic [3:0] tx_win;
  logic rx_take;
  logic tx_take;
  logic buf_acc;
  logic ctl_wr;
  logic [3:0] ctl_idx;

  assign buf_acc = (reg_wr || reg_rd) && reg_addr == A_BUF;
  assign ctl_idx = reg_addr[3:0];
  assign ctl_wr = reg_wr && reg_addr[7:4] == A_CTL[7:4]
    && ctl_idx != 4'h0;

  // ---------------------------------------------------------------
  // acceptance filter
  // ---------------------------------------------------------------
  always_comb
  begin
    logic [28:0] im;
    logic [15:0] mm;
    logic [15:0] md;
    logic idm;
    im = '0;
    mm = '0;
    md = '0;
    idm = 1'b0;
    hit = '0;
    ans = '0;
    for (int c = 1; c <= NC; c++)
    begin
      im = cctl[c][C_MSK] ? id_mask : IDMSK_RST;
      mm = cctl[c][C_MSK] ? media_mask : 16'hFFFF;
      md = (rx_data[15:0] ^ {media_arb_byte_hi, media_arb_byte_lo}) & mm;
      idm = id_ok(mem[mbase(4'(c))][28:0], rx_id, rx_ide, im)
        && cctl[c][C_EXT] == rx_ide;
      if (c < NC)
      begin
        hit[c-1] = !rx_rtr && cctl[c][C_RDY] && !cctl[c][C_DIR]
          && idm && md == 16'h0000;
        ans[c-1] = rx_rtr && idm && cctl[c][C_DIR]
          && !cctl[c][C_TIH] && cctl[c][C_DATA_UPDATED]
          && cctl[c][C_RDY] && cctl[c][C_TRQ];
      end
    end
    hit[NC-1] = !rx_rtr && cctl[NC][C_RDY] && hit[NC-2:0] == '0;
  end

  assign rx_win = low_idx(hit);
  assign tx_win = low_idx(ans);
  assign rx_take = rx_valid && can_enable && rx_win != 4'h0;
  assign tx_take = rx_valid && can_enable && tx_win != 4'h0;

  // ---------------------------------------------------------------
  // shared message memory
  // ---------------------------------------------------------------
  // one store for ids and data
  always_ff @(posedge clk_sys)
  begin
    if (buf_acc && reg_wr)
      mem[can_mem_pointer] <= reg_wdata;
    if (rx_take)
    begin
      if (rx_win == 4'(NC))
        mem[mbase(rx_win)] <= {2'b00, rx_ide, rx_id};
      mem[mbase(rx_win) + 6'h1] <= rx_data[31:0];
      mem[mbase(rx_win) + 6'h2] <= rx_data[63:32];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      eng_rdata <= 32'h0000_0000;
    else if (eng_rd)
      eng_rdata <= mem[eng_addr];
  end

  // pointer steps after each buffer access
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      can_mem_pointer <= '0;
    else if (reg_wr && reg_addr == A_PTR)
      can_mem_pointer <= reg_wdata[PW-1:0];
    else if (buf_acc)
      can_mem_pointer <= can_mem_pointer + 6'h1;
  end

  // ---------------------------------------------------------------
  // global registers
  // ---------------------------------------------------------------
  // timing, mask and media settings
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      can_enable <= 1'b0;
      bit_timing <= BTIME_RST;
      id_mask <= IDMSK_RST;
      media_arb_byte_lo <= 8'h00;
      media_arb_byte_hi <= 8'h00;
      media_mask <= MAMSK_RST;
      int_mask <= 16'h0000;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        A_GCTRL: can_enable <= reg_wdata[0];
        A_BTIME: bit_timing <= reg_wdata[15:0];
        A_IDMSK: id_mask <= reg_wdata[28:0];
        A_MALO: media_arb_byte_lo <= reg_wdata[7:0];
        A_MAHI: media_arb_byte_hi <= reg_wdata[7:0];
        A_MAMSK: media_mask <= reg_wdata[15:0];
        A_IMASK: int_mask <= reg_wdata[15:0];
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // center controls
  // ---------------------------------------------------------------
  // per-center control words
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int c = 1; c <= NC; c++)
        cctl[c] <= CTL_RST;
    end
    else
    begin
      for (int c = 1; c <= NC; c++)
      begin
        logic [15:0] nx;
        nx = cctl[c];
        if (ctl_wr && ctl_idx == 4'(c))
          nx = reg_wdata[15:0];
        if (c == NC)
          nx[C_DIR] = 1'b0;
        // new data marked with its length
        if (rx_take && rx_win == 4'(c))
        begin
          nx[C_DATA_UPDATED] = 1'b1;
          nx[C_DLC+:4] = rx_dlc;
        end
        if (tx_take && tx_win == 4'(c))
          nx[C_TRQ] = 1'b0;
        cctl[c] <= nx;
      end
    end
  end

  // ---------------------------------------------------------------
  // events and interrupt
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      int_status <= 16'h0000;
    else
    begin
      logic [15:0] nx;
      nx = int_status;
      if (reg_wr && reg_addr == A_ISTAT)
        nx = nx & ~reg_wdata[15:0];
      if (rx_take && cctl[rx_win][C_IEN])
        nx[rx_win - 4'h1] = 1'b1;
      if (tx_take && cctl[tx_win][C_IEN])
        nx[tx_win - 4'h1] = 1'b1;
      if (rx_take && cctl[rx_win][C_DATA_UPDATED])
        nx[S_OVR] = 1'b1;
      int_status <= nx;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      irq <= 1'b0;
    else
      irq <= |(int_status & int_mask);
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_go <= 1'b0;
      tx_center <= 4'h0;
      rx_stored <= 1'b0;
      last_src <= 4'h0;
    end
    else
    begin
      tx_go <= tx_take;
      rx_stored <= rx_take;
      if (tx_take)
        tx_center <= tx_win;
      if (rx_take)
        last_src <= rx_win;
    end
  end

  // ---------------------------------------------------------------
  // register read
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= 32'h0000_0000;
    else if (reg_rd)
    begin
      reg_rdata <= 32'h0000_0000;
      case (reg_addr)
        A_GCTRL: reg_rdata[0] <= can_enable;
        A_BTIME: reg_rdata[15:0] <= bit_timing;
        A_IDMSK: reg_rdata[28:0] <= id_mask;
        A_MALO: reg_rdata[7:0] <= media_arb_byte_lo;
        A_MAHI: reg_rdata[7:0] <= media_arb_byte_hi;
        A_MAMSK: reg_rdata[15:0] <= media_mask;
        A_ISTAT: reg_rdata[15:0] <= int_status;
        A_IMASK: reg_rdata[15:0] <= int_mask;
        A_SRC: reg_rdata[3:0] <= last_src;
        A_PTR: reg_rdata[PW-1:0] <= can_mem_pointer;
        A_BUF: reg_rdata <= mem[can_mem_pointer];
        default:
          if (ctl_wr || (reg_addr[7:4] == A_CTL[7:4] && ctl_idx != 4'h0))
            reg_rdata[15:0] <= cctl[ctl_idx];
      endcase
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  sequence s_rx_low;
    rx_valid && can_enable && hit != '0;
  endsequence
  sequence s_remote;
    rx_valid && can_enable && rx_rtr && ans != '0;
  endsequence
  property p_low_win;
    s_rx_low |=> rx_stored && last_src == low_idx($past(hit));
  endproperty
  a_low_win: assert property (p_low_win)
    else $error("stored center is not the lowest match");
  property p_catch;
    s_rx_low ##0 hit[NC-2:0] == '0 |=> last_src == 4'(NC);
  endproperty
  a_catch: assert property (p_catch)
    else $error("unaccepted frame missed center fifteen");
  property p_format;
    s_rx_low ##0 rx_win != 4'(NC) |=> cctl[last_src][C_EXT] == $past(rx_ide);
  endproperty
  a_format: assert property (p_format)
    else $error("center took frame of the other format");
  property p_answer;
    s_remote |=> tx_go && tx_center == $past(tx_win)
      ##1 tx_go == $past(tx_take);
  endproperty
  a_answer: assert property (p_answer)
    else $error("remote frame not answered for one cycle");
  property p_tx_cause;
    tx_go |-> $past(rx_rtr && rx_valid) && cctl[tx_center][C_DIR];
  endproperty
  a_tx_cause: assert property (p_tx_cause)
    else $error("transmit without remote frame or tx center");
  property p_data_updated;
    s_rx_low |=> cctl[last_src][C_DATA_UPDATED] && !tx_go;
  endproperty
  a_data_updated: assert property (p_data_updated)
    else $error("received center not marked updated");
  property p_buf_rd;
    logic [PW-1:0] p;
    (reg_rd && reg_addr == A_BUF && !reg_wr, p = can_mem_pointer)
      |=> reg_rdata == mem[p] && can_mem_pointer == p + 6'h1;
  endproperty
  a_buf_rd: assert property (p_buf_rd)
    else $error("buffer read wrong word or pointer not stepped");
  property p_irq;
    (int_status & int_mask) != 16'h0000 |=> irq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt missing for unmasked status");
  property p_media;
    rx_valid && !rx_rtr && hit[0] |->
      ((rx_data[15:0] ^ {media_arb_byte_hi, media_arb_byte_lo})
      & (cctl[1][C_MSK] ? media_mask : 16'hFFFF)) == 16'h0000;
  endproperty
  a_media: assert property (p_media)
    else $error("center one hit with media bytes unequal");
  property p_rx_only;
    !rx_valid ##1 !rx_valid |-> !rx_stored && !tx_go;
  endproperty
  a_rx_only: assert property (p_rx_only)
    else $error("store or answer without a frame");
endmodule

// file: cmcf_node_model.sv
// far-side protocol engine model: offers frames, reads memory
module cmcf_node_model
  import cmcf_pkg::*;
(
  input wire logic clk_sys,
  output logic rx_valid,
  output logic rx_ide,
  output logic rx_rtr,
  output logic [28:0] rx_id,
  output logic [3:0] rx_dlc,
  output logic [63:0] rx_data,
  output logic eng_rd,
  output logic [5:0] eng_addr,
  input wire logic [31:0] eng_rdata,
  input wire logic tx_go,
  input wire logic [3:0] tx_center,
  input wire logic rx_stored
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    rx_valid = 1'b0;
    rx_ide = 1'b0;
    rx_rtr = 1'b0;
    rx_id = 29'h0000_0000;
    rx_dlc = 4'h0;
    rx_data = 64'h0000_0000_0000_0000;
    eng_rd = 1'b0;
    eng_addr = 6'h00;
  end
  // -------------------------------------------------------------
  // frame offer, lines inverted once released
  // -------------------------------------------------------------
  // frame and answer
  task automatic send(input logic ide, input logic rtr,
    input logic [28:0] id, input logic [63:0] d,
    output logic st, output logic go, output logic [3:0] ctr);
    @(posedge clk_sys);
    rx_valid <= 1'b1;
    rx_ide <= ide;
    rx_rtr <= rtr;
    rx_id <= id;
    rx_dlc <= 4'h8;
    rx_data <= d;
    @(posedge clk_sys);
    rx_valid <= 1'b0;
    rx_ide <= ~ide;
    rx_rtr <= ~rtr;
    rx_id <= ~id;
    rx_dlc <= 4'h7;
    rx_data <= ~d;
    #1;
    st = rx_stored;
    go = tx_go;
    ctr = tx_center;
  endtask
  task automatic eng_read(input logic [5:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    eng_rd <= 1'b1;
    eng_addr <= a;
    @(posedge clk_sys);
    eng_rd <= 1'b0;
    eng_addr <= ~a;
    #1;
    d = eng_rdata;
  endtask
endmodule

// file: cmcf_tb_top.sv
// self-checking bench for the message center filter block
`define CHK(n, e, g) chk(n, e, g)
module cmcf_tb_top
  import cmcf_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys, rst_n, reg_wr, reg_rd, rx_valid, rx_ide, rx_rtr, eng_rd;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, eng_rdata, d;
  logic [28:0] rx_id;
  logic [3:0] rx_dlc, tx_center, ctr;
  logic [63:0] rx_data;
  logic [5:0] eng_addr;
  logic tx_go, rx_stored, can_enable, irq, st, go;
  logic [15:0] bit_timing;
  int bad_count = 0;
  int num_checks = 0;
  localparam logic [63:0] DAT = 64'h8877_6655_4433_2211;
  localparam logic [63:0] BAD = 64'h8877_6655_4433_2299;
  cmcf_top i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .rx_valid(rx_valid), .rx_ide(rx_ide),
    .rx_rtr(rx_rtr), .rx_id(rx_id), .rx_dlc(rx_dlc), .rx_data(rx_data),
    .eng_rd(eng_rd), .eng_addr(eng_addr), .eng_rdata(eng_rdata),
    .tx_go(tx_go), .tx_center(tx_center), .rx_stored(rx_stored),
    .can_enable(can_enable), .bit_timing(bit_timing), .irq(irq));
  cmcf_node_model i_node (.clk_sys(clk_sys), .rx_valid(rx_valid),
    .rx_ide(rx_ide), .rx_rtr(rx_rtr), .rx_id(rx_id), .rx_dlc(rx_dlc),
    .rx_data(rx_data), .eng_rd(eng_rd), .eng_addr(eng_addr),
    .eng_rdata(eng_rdata), .tx_go(tx_go), .tx_center(tx_center),
    .rx_stored(rx_stored));
  // -------------------------------------------------------------
  // clock, checks and bus tasks
  // -------------------------------------------------------------
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  task automatic chk(input string n, input logic [31:0] e,
    input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask
  task automatic setc(input int c, input logic [28:0] id,
    input logic [31:0] ctl);
    wr(A_PTR, 32'((c - 1) * 4));
    wr(A_BUF, {3'b000, id});
    wr(A_CTL + 8'(c), ctl);
  endtask
  task automatic frame(input logic ide, input logic rtr,
    input logic [28:0] id, input logic [63:0] dt);
    i_node.send(ide, rtr, id, dt, st, go, ctr);
  endtask
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    bad_count++;
    report_and_stop();
  end
  // -------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------
  initial
  begin
    rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(A_IDMSK, d);
    `CHK("idmask", 32'h1FFF_FFFF, d);
    rd(A_CTL + 8'h01, d);
    `CHK("ctl1", 32'h0000_0000, d);
    rd(8'h30, d);
    `CHK("unmapped", 32'h0000_0000, d);
    `CHK("irq", 32'h0000_0000, irq);
    wr(A_GCTRL, 32'h0000_0001);
    wr(A_BTIME, 32'h0000_1234);
    `CHK("timing", 32'h0000_1234, bit_timing);
    `CHK("enable", 32'h0000_0001, can_enable);
    $display("test reset done");
    setc(1, 29'h0000_0123, 32'h0000_0012);
    setc(2, 29'h0000_0123, 32'h0000_0012);
    setc(3, 29'h0000_0450, 32'h0000_0092);
    setc(4, 29'h0000_0200, 32'h0000_0039);
    setc(5, 29'h1ABC_0123, 32'h0000_0014);
    setc(15, 29'h0000_0000, 32'h0000_0012);
    wr(A_MALO, 32'h0000_0011);
    wr(A_MAHI, 32'h0000_0022);
    wr(A_IDMSK, 32'h1FFF_FFF0);
    wr(A_IMASK, 32'h0000_7FFF);
    i_node.eng_read(6'd8, d);
    `CHK("eng id3", 32'h0000_0450, d);
    wr(A_PTR, 32'h0000_0004);
    rd(A_BUF, d);
    `CHK("buf id2", 32'h0000_0123, d);
    $display("test memory done");
    frame(1'b0, 1'b0, 29'h0000_0123, DAT);
    `CHK("stored", 32'h0000_0001, st);
    rd(A_SRC, d);
    `CHK("src", 32'h0000_0001, d);
    rd(A_ISTAT, d);
    `CHK("istat", 32'h0000_0001, d);
    `CHK("irq set", 32'h0000_0001, irq);
    i_node.eng_read(6'd1, d);
    `CHK("data lo", 32'h4433_2211, d);
    i_node.eng_read(6'd2, d);
    `CHK("data hi", 32'h8877_6655, d);
    rd(A_CTL + 8'h01, d);
    `CHK("ctl1 dlc", 32'h0000_8008, d & 32'h0000_F008);
    wr(A_ISTAT, 32'h0000_0001);
    rd(A_ISTAT, d);
    `CHK("istat clr", 32'h0000_0000, d);
    `CHK("irq clr", 32'h0000_0000, irq);
    $display("test receive done");
    wr(A_IMASK, 32'h0000_0000);
    frame(1'b0, 1'b0, 29'h0000_0123, BAD);
    rd(A_SRC, d);
    `CHK("src media", 32'h0000_000F, d);
    frame(1'b1, 1'b0, 29'h0000_0123, DAT);
    rd(A_SRC, d);
    `CHK("src format", 32'h0000_000F, d);
    rd(A_ISTAT, d);
    `CHK("overrun", 32'h0000_C000, d);
    `CHK("irq masked", 32'h0000_0000, irq);
    i_node.eng_read(6'd56, d);
    `CHK("c15 id", 32'h2000_0123, d);
    $display("test catch-all done");
    frame(1'b0, 1'b0, 29'h0000_045A, DAT);
    rd(A_SRC, d);
    `CHK("src masked", 32'h0000_0003, d);
    frame(1'b1, 1'b0, 29'h1ABC_0123, DAT);
    rd(A_SRC, d);
    `CHK("src ext", 32'h0000_0005, d);
    $display("test mask done");
    frame(1'b0, 1'b1, 29'h0000_0200, DAT);
    `CHK("tx go", 32'h0000_0001, go);
    `CHK("tx ctr", 32'h0000_0004, ctr);
    rd(A_CTL + 8'h04, d);
    `CHK("trq clr", 32'h0000_0000, d & 32'h0000_0020);
    wr(A_CTL + 8'h04, 32'h0000_0079);
    frame(1'b0, 1'b1, 29'h0000_0200, DAT);
    `CHK("inhibit", 32'h0000_0000, go);
    $display("test remote done");
    wr(A_GCTRL, 32'h0000_0000);
    frame(1'b0, 1'b0, 29'h0000_0123, DAT);
    `CHK("disabled", 32'h0000_0000, st);
    $display("test disable done");
    report_and_stop();
  end
endmodule
